// ### pmcs_map.vh
/*
  Constants of the power monitor sequencing and scaling block: conversion
  times, averaging codes, limit and calibration reset values, scaling shifts.
  Assumes it is included by bare name from the design files.
*/
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH

// Clock and conversion times
`define PMCS_CLK_PERIOD_NS 10
`define PMCS_CYC_PER_US    (1000 / `PMCS_CLK_PERIOD_NS)
`define PMCS_CT0_US        50
`define PMCS_CT1_US        84
`define PMCS_CT2_US        150
`define PMCS_CT3_US        280
`define PMCS_CT4_US        540
`define PMCS_CT5_US        1052
`define PMCS_CT6_US        2074
`define PMCS_CT7_US        4120

// Averaging counts as powers of two
`define PMCS_AVG0_LOG2     4'h0
`define PMCS_AVG1_LOG2     4'h2
`define PMCS_AVG2_LOG2     4'h4
`define PMCS_AVG3_LOG2     4'h6
`define PMCS_AVG4_LOG2     4'h7
`define PMCS_AVG5_LOG2     4'h8
`define PMCS_AVG6_LOG2     4'h9
`define PMCS_AVG7_LOG2     4'hA

// Channels in conversion order
`define PMCS_CH_SHUNT      2'h0
`define PMCS_CH_BUS        2'h1
`define PMCS_CH_TEMP       2'h2

// Limit and calibration write selects
`define PMCS_SEL_SHUNT_LIM 2'h0
`define PMCS_SEL_BUS_LIM   2'h1
`define PMCS_SEL_PWR_LIM   2'h2
`define PMCS_SEL_CAL       2'h3

// Reset values
`define PMCS_SHUNT_LIM_RST 16'h7FFF
`define PMCS_BUS_LIM_RST   15'h7FFF
`define PMCS_PWR_LIM_RST   16'hFFFF
`define PMCS_CAL_RST       15'h0000

// Scaling
`define PMCS_CUR_SHIFT     12
`define PMCS_PWR_SHIFT     6
`define PMCS_PWR_LIM_SHIFT 8

`endif

// ### pmcs_avg.v
/*
  Averaging accumulator: sums signed conversion results and returns the
  sum shifted right by the log2 of the averaging count.
  Assumes the caller clears it at the start of each averaging window.
*/
`timescale 1ns/1ps
`default_nettype none

module pmcs_avg #(
  parameter W  = 16,
  parameter LW = 10
) (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 clr,
  input  wire                 add,
  input  wire signed [W-1:0]  sample,
  input  wire        [3:0]    shift,
  output wire signed [W-1:0]  result
);

  reg  signed [W+LW-1:0] acc_q;
  wire signed [W+LW-1:0] sx;
  wire signed [W+LW-1:0] shifted;

  assign sx      = {{LW{sample[W-1]}}, sample};
  assign shifted = acc_q >>> shift;
  // Sum of at most 2**LW samples divided by the count always fits W bits
  assign result  = shifted[W-1:0];

  always @(posedge clk) begin
    if (rst) begin
      acc_q <= {(W+LW){1'b0}};
    end else if (clr && add) begin
      acc_q <= sx;
    end else if (clr) begin
      acc_q <= {(W+LW){1'b0}};
    end else if (add) begin
      acc_q <= acc_q + sx;
    end
  end

endmodule // pmcs_avg

`default_nettype wire

// ### pmcs_top.v
/*
  Conversion sequencing, averaging, current and power scaling, limit
  comparison and alert of a shunt and bus power monitor.
  Assumes an analog front end that converts the channel on ADC_CHAN over
  the programmed time and holds its signed result on ADC_SAMPLE at the end;
  RST stands for the supply power cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Eight selectable conversion times, 50 to 4120 us
// - Averaging over 1 to 1024 conversions
// - Sample period is the sum of the three conversion times times count
// - Time and averaging are independent settings
// - Separate shunt and bus conversion times
// - Power-up: wide range, continuous three-channel conversion
// - Limits return to reset values each power-up
// - Current results zero until calibration written
// - 16-bit power limit compared at 256 steps
// - Shunt result compared with shunt upper limit
// - Bus result compared with bus upper limit
// - Power step is 0.2 times current step
// - Results except power in two's complement, MSB negative
// - Alert selects limit event or conversion ready
// - Shunt range selectable, wide or narrow
// - Measure bus voltage and compute power
// - Current computed after shunt measurement from calibration
module pmcs_top #(
  parameter CYC_PER_US = `PMCS_CYC_PER_US
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire [2:0]  SHUNT_CT_SEL,
  input  wire [2:0]  BUS_CT_SEL,
  input  wire [2:0]  TEMP_CT_SEL,
  input  wire [2:0]  AVG_SEL,
  input  wire        SHUNT_RANGE_SELECT,
  input  wire        ALERT_SEL,
  input  wire        LIM_WR,
  input  wire [1:0]  LIM_ADDR,
  input  wire [15:0] LIM_WDATA,
  input  wire        READY_CLR,
  input  wire [15:0] ADC_SAMPLE,
  output wire [1:0]  ADC_CHAN,
  output wire        ADC_RANGE,
  output wire        ADC_SOC,
  output wire [15:0] SHUNT_RES,
  output wire [15:0] BUS_RES,
  output wire [15:0] TEMP_RES,
  output wire [15:0] CURRENT_RES,
  output wire [23:0] POWER_RES,
  output wire        DATA_READY,
  output wire        OVER_SHUNT,
  output wire        OVER_BUS,
  output wire        OVER_POWER,
  output wire        ALERT_O,
  output wire        ALERT_OE
);

  //////////////////////////////////////////////////////////////////////////
  // States
  localparam [5:0] S_LOAD  = 6'b000001;
  localparam [5:0] S_CONV  = 6'b000010;
  localparam [5:0] S_STORE = 6'b000100;
  localparam [5:0] S_CUR   = 6'b001000;
  localparam [5:0] S_PWR   = 6'b010000;
  localparam [5:0] S_CMP   = 6'b100000;

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Conversion time code to clock cycles
  function [19:0] ct_cyc;
    input [2:0] sel;
    integer t;
    begin
      case (sel)
        3'h0:    t = `PMCS_CT0_US * CYC_PER_US;
        3'h1:    t = `PMCS_CT1_US * CYC_PER_US;
        3'h2:    t = `PMCS_CT2_US * CYC_PER_US;
        3'h3:    t = `PMCS_CT3_US * CYC_PER_US;
        3'h4:    t = `PMCS_CT4_US * CYC_PER_US;
        3'h5:    t = `PMCS_CT5_US * CYC_PER_US;
        3'h6:    t = `PMCS_CT6_US * CYC_PER_US;
        default: t = `PMCS_CT7_US * CYC_PER_US;
      endcase
      if (t < 1) begin
        t = 1;
      end
      ct_cyc = t[19:0];
    end
  endfunction

  // Averaging code to log2 of the count
  function [3:0] avg_log2;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    avg_log2 = `PMCS_AVG0_LOG2;
        3'h1:    avg_log2 = `PMCS_AVG1_LOG2;
        3'h2:    avg_log2 = `PMCS_AVG2_LOG2;
        3'h3:    avg_log2 = `PMCS_AVG3_LOG2;
        3'h4:    avg_log2 = `PMCS_AVG4_LOG2;
        3'h5:    avg_log2 = `PMCS_AVG5_LOG2;
        3'h6:    avg_log2 = `PMCS_AVG6_LOG2;
        default: avg_log2 = `PMCS_AVG7_LOG2;
      endcase
    end
  endfunction

  // Signed saturation to 16 bits
  function [15:0] sat16;
    input signed [31:0] v;
    begin
      if (v > 32'sd32767) begin
        sat16 = 16'h7FFF;
      end else if (v < -32'sd32768) begin
        sat16 = 16'h8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Registers
  reg        [5:0]  state_q;
  reg        [19:0] cyc_q;
  reg        [19:0] ct_q;
  reg        [10:0] n_q;
  reg        [10:0] navg_q;
  reg        [3:0]  shift_q;
  reg        [1:0]  chan_q;
  reg               range_q;
  reg               soc_q;
  reg signed [15:0] shunt_q;
  reg        [15:0] bus_q;
  reg        [15:0] temp_q;
  reg signed [15:0] cur_q;
  reg        [23:0] pwr_q;
  reg signed [15:0] shunt_lim_q;
  reg        [14:0] bus_lim_q;
  reg        [15:0] pwr_lim_q;
  reg        [14:0] cal_q;
  reg               ready_q;
  reg               ov_shunt_q;
  reg               ov_bus_q;
  reg               ov_pwr_q;
  reg               alert_oe_q;
  reg               alert_o_q;

  wire signed [15:0] avg_res;
  wire               conv_end;
  wire               win_end;
  wire signed [31:0] cur_prod;
  wire signed [31:0] cur_scaled;
  wire        [15:0] cur_mag;
  wire        [15:0] bus_pos;
  wire        [31:0] pwr_prod;
  wire        [31:0] pwr_scaled;
  wire               cmp_state;
  wire               ready_set;

  //////////////////////////////////////////////////////////////////////////
  // Averager
  pmcs_avg #(
    .W  (16),
    .LW (10)
  ) u_avg (
    .clk    (CLK),
    .rst    (RST),
    .clr    (state_q == S_LOAD),
    .add    (conv_end),
    .sample (ADC_SAMPLE),
    .shift  (shift_q),
    .result (avg_res)
  );

  assign conv_end = (state_q == S_CONV) && (cyc_q == ct_q - 20'h0_0001);
  assign win_end  = conv_end && (n_q == navg_q - 11'h001);

  //////////////////////////////////////////////////////////////////////////
  // Scaling
  // Calibration of zero forces a zero product, so current and power read 0
  assign cur_prod   = $signed({{16{shunt_q[15]}}, shunt_q}) *
                      $signed({17'h0_0000, cal_q});
  assign cur_scaled = cur_prod >>> `PMCS_CUR_SHIFT;
  assign cur_mag    = cur_q[15] ? (16'h0000 - cur_q) : cur_q;
  // Bus is positive only; a negative code is treated as zero
  assign bus_pos    = bus_q[15] ? 16'h0000 : bus_q;
  assign pwr_prod   = {16'h0000, cur_mag} * {16'h0000, bus_pos};
  assign pwr_scaled = pwr_prod >> `PMCS_PWR_SHIFT;

  assign cmp_state = (state_q == S_CMP);
  assign ready_set = cmp_state;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge CLK) begin
    if (RST) begin
      state_q <= S_LOAD;
      cyc_q   <= 20'h0_0000;
      ct_q    <= 20'h0_0001;
      n_q     <= 11'h000;
      navg_q  <= 11'h001;
      shift_q <= 4'h0;
      chan_q  <= `PMCS_CH_SHUNT;
      range_q <= 1'b0;
      soc_q   <= 1'b0;
      shunt_q <= 16'h0000;
      bus_q   <= 16'h0000;
      temp_q  <= 16'h0000;
      cur_q   <= 16'h0000;
      pwr_q   <= 24'h00_0000;
    end else begin
      soc_q <= 1'b0;
      case (state_q)
        S_LOAD: begin
          // Settings are taken once per window so a change cannot split it
          case (chan_q)
            `PMCS_CH_SHUNT: ct_q <= ct_cyc(SHUNT_CT_SEL);
            `PMCS_CH_BUS:   ct_q <= ct_cyc(BUS_CT_SEL);
            default:        ct_q <= ct_cyc(TEMP_CT_SEL);
          endcase
          shift_q <= avg_log2(AVG_SEL);
          navg_q  <= 11'h001 << avg_log2(AVG_SEL);
          range_q <= SHUNT_RANGE_SELECT;
          n_q     <= 11'h000;
          cyc_q   <= 20'h0_0000;
          soc_q   <= 1'b1;
          state_q <= S_CONV;
        end
        S_CONV: begin
          if (win_end) begin
            state_q <= S_STORE;
          end else if (conv_end) begin
            n_q   <= n_q + 11'h001;
            cyc_q <= 20'h0_0000;
            soc_q <= 1'b1;
          end else begin
            cyc_q <= cyc_q + 20'h0_0001;
          end
        end
        S_STORE: begin
          case (chan_q)
            `PMCS_CH_SHUNT: begin
              shunt_q <= avg_res;
              chan_q  <= `PMCS_CH_BUS;
              state_q <= S_LOAD;
            end
            `PMCS_CH_BUS: begin
              bus_q   <= avg_res;
              chan_q  <= `PMCS_CH_TEMP;
              state_q <= S_LOAD;
            end
            default: begin
              temp_q  <= {avg_res[15:4], 4'h0};
              state_q <= S_CUR;
            end
          endcase
        end
        S_CUR: begin
          cur_q   <= sat16(cur_scaled);
          state_q <= S_PWR;
        end
        S_PWR: begin
          if (pwr_prod[31:30] != 2'b00) begin
            pwr_q <= 24'hFF_FFFF;
          end else begin
            pwr_q <= pwr_scaled[23:0];
          end
          state_q <= S_CMP;
        end
        S_CMP: begin
          chan_q  <= `PMCS_CH_SHUNT;
          state_q <= S_LOAD;
        end
        default: begin
          chan_q  <= `PMCS_CH_SHUNT;
          state_q <= S_LOAD;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Limits and calibration
  always @(posedge CLK) begin
    if (RST) begin
      shunt_lim_q <= `PMCS_SHUNT_LIM_RST;
      bus_lim_q   <= `PMCS_BUS_LIM_RST;
      pwr_lim_q   <= `PMCS_PWR_LIM_RST;
      cal_q       <= `PMCS_CAL_RST;
    end else if (LIM_WR) begin
      case (LIM_ADDR)
        `PMCS_SEL_SHUNT_LIM: shunt_lim_q <= LIM_WDATA;
        `PMCS_SEL_BUS_LIM:   bus_lim_q   <= LIM_WDATA[14:0];
        `PMCS_SEL_PWR_LIM:   pwr_lim_q   <= LIM_WDATA;
        default:             cal_q       <= LIM_WDATA[14:0];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Comparison and alert
  always @(posedge CLK) begin
    if (RST) begin
      ov_shunt_q <= 1'b0;
      ov_bus_q   <= 1'b0;
      ov_pwr_q   <= 1'b0;
      ready_q    <= 1'b0;
      alert_oe_q <= 1'b0;
      alert_o_q  <= 1'b0;
    end else begin
      if (cmp_state) begin
        ov_shunt_q <= (shunt_q > shunt_lim_q);
        ov_bus_q   <= (bus_pos[14:0] > bus_lim_q);
        ov_pwr_q   <= (pwr_q[23:`PMCS_PWR_LIM_SHIFT] > pwr_lim_q);
      end
      // A ready event in the clear cycle is kept
      if (ready_set) begin
        ready_q <= 1'b1;
      end else if (READY_CLR) begin
        ready_q <= 1'b0;
      end
      // Open drain: the pin is pulled low whenever the enable is high
      if (ALERT_SEL) begin
        alert_oe_q <= ready_q;
      end else begin
        alert_oe_q <= ov_shunt_q | ov_bus_q | ov_pwr_q;
      end
      alert_o_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ADC_CHAN    = chan_q;
  assign ADC_RANGE   = range_q;
  assign ADC_SOC     = soc_q;
  assign SHUNT_RES   = shunt_q;
  assign BUS_RES     = bus_q;
  assign TEMP_RES    = temp_q;
  assign CURRENT_RES = cur_q;
  assign POWER_RES   = pwr_q;
  assign DATA_READY  = ready_q;
  assign OVER_SHUNT  = ov_shunt_q;
  assign OVER_BUS    = ov_bus_q;
  assign OVER_POWER  = ov_pwr_q;
  assign ALERT_O     = alert_o_q;
  assign ALERT_OE    = alert_oe_q;

endmodule // pmcs_top

`default_nettype wire

// ### pmcs_props.sv
/* Checker of the power monitor sequencing block at its top ports.
   Assumes pmcs_top with one clock CLK and a synchronous reset RST. */
`timescale 1ns/1ps
`default_nettype none
module pmcs_props #(
  parameter CYC_PER_US = 100
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        ALERT_SEL,
  input wire logic        READY_CLR,
  input wire logic [1:0]  ADC_CHAN,
  input wire logic        ADC_RANGE,
  input wire logic        ADC_SOC,
  input wire logic [15:0] TEMP_RES,
  input wire logic [15:0] CURRENT_RES,
  input wire logic [23:0] POWER_RES,
  input wire logic        DATA_READY,
  input wire logic        OVER_SHUNT,
  input wire logic        OVER_BUS,
  input wire logic        OVER_POWER,
  input wire logic        ALERT_O,
  input wire logic        ALERT_OE
);
  // Longest wait between starts: slowest conversion plus step overhead
  localparam int GAP = 4130 * CYC_PER_US + 32;
  logic [23:0] gap_q;
  always @(posedge CLK)
    gap_q <= (RST || ADC_SOC) ? 24'h00_0000 : gap_q + 24'h00_0001;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////
  soc_pulse_a: assert property (ADC_SOC |=> !ADC_SOC)
    else $error("start pulse longer than one cycle");
  conv_runs_a: assert property (gap_q < GAP)
    else $error("conversions stopped");
  chan_legal_a: assert property (ADC_CHAN != 2'h3)
    else $error("illegal channel");
  chan_load_a: assert property ($changed(ADC_CHAN) |-> ##[1:4] ADC_SOC)
    else $error("channel changed outside window start");
  range_load_a: assert property ($changed(ADC_RANGE) |-> ADC_SOC)
    else $error("range changed outside window start");
  flag_set_a: assert property (
    $changed({OVER_SHUNT, OVER_BUS, OVER_POWER}) |-> DATA_READY)
    else $error("flags moved without a finished set");
  ready_hold_a: assert property (DATA_READY && !READY_CLR |=> DATA_READY)
    else $error("ready dropped by itself");
  alert_flag_a: assert property (!$past(ALERT_SEL) |->
    ALERT_OE == $past(OVER_SHUNT || OVER_BUS || OVER_POWER))
    else $error("alert does not follow flags");
  alert_rdy_a: assert property ($past(ALERT_SEL) |->
    ALERT_OE == $past(DATA_READY))
    else $error("alert does not follow ready");
  alert_pin_a: assert property (ALERT_O == 1'b0)
    else $error("alert pin driven high");
  pwr_zero_a: assert property (
    $rose(DATA_READY) && CURRENT_RES == 16'h0000 |-> POWER_RES == 0)
    else $error("power without current");
  temp_lsb_a: assert property (TEMP_RES[3:0] == 4'h0)
    else $error("temperature low bits set");
endmodule // pmcs_props
bind pmcs_top pmcs_props #(.CYC_PER_US(CYC_PER_US)) u_props (.*);
`default_nettype wire

// ### pmcs_adc_model.sv
/* Analog front end model: returns the programmed code of the channel.
   Assumes the block samples only late in each conversion. */
`timescale 1ns/1ps
`default_nettype none
module pmcs_adc_model (
  input  wire logic        clk,
  input  wire logic [1:0]  adc_chan,
  input  wire logic        adc_soc,
  input  wire logic [15:0] shunt_v,
  input  wire logic [15:0] bus_v,
  input  wire logic [15:0] temp_v,
  output logic      [15:0] adc_sample
);
  logic        soc_q;
  logic [15:0] v;
  always @(posedge clk) soc_q <= adc_soc;
  assign v = adc_chan == 2'h0 ? shunt_v : adc_chan == 2'h1 ? bus_v : temp_v;
  // Wrong data early in a conversion catches a too-early sample
  assign adc_sample = (adc_soc || soc_q) ? ~v : v;
endmodule // pmcs_adc_model
`default_nettype wire

// ### pmcs_top_test.sv
/* Self-checking bench of pmcs_top with a front end model.
   Assumes CYC_PER_US of 1, so one microsecond is one cycle. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pmcs_top_test;
  logic CLK = 0, RST = 1, SHUNT_RANGE_SELECT = 0, ALERT_SEL = 0;
  logic LIM_WR = 0, READY_CLR = 0, ADC_RANGE, ADC_SOC, DATA_READY, ALERT_O;
  logic OVER_SHUNT, OVER_BUS, OVER_POWER, ALERT_OE;
  logic [2:0]  SHUNT_CT_SEL = 0, BUS_CT_SEL = 0, TEMP_CT_SEL = 0, AVG_SEL = 0;
  logic [1:0]  LIM_ADDR = 0, ADC_CHAN;
  logic [15:0] LIM_WDATA = 0, ADC_SAMPLE, SHUNT_RES, BUS_RES, TEMP_RES;
  logic [15:0] CURRENT_RES, shunt_v = 16'h4BF0, bus_v = 16'h3C00;
  logic [15:0] temp_v = 16'h0C80;
  logic [23:0] POWER_RES, e24;
  int          n_fail = 0, checks = 0, cyc, socs, c0;
  int          ct_us [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  always #5 CLK = ~CLK;
  pmcs_top #(.CYC_PER_US(1)) dut (.CLK(CLK), .RST(RST),
    .SHUNT_CT_SEL(SHUNT_CT_SEL), .BUS_CT_SEL(BUS_CT_SEL),
    .TEMP_CT_SEL(TEMP_CT_SEL), .AVG_SEL(AVG_SEL),
    .SHUNT_RANGE_SELECT(SHUNT_RANGE_SELECT), .ALERT_SEL(ALERT_SEL),
    .LIM_WR(LIM_WR), .LIM_ADDR(LIM_ADDR), .LIM_WDATA(LIM_WDATA),
    .READY_CLR(READY_CLR), .ADC_SAMPLE(ADC_SAMPLE), .ADC_CHAN(ADC_CHAN),
    .ADC_RANGE(ADC_RANGE), .ADC_SOC(ADC_SOC), .SHUNT_RES(SHUNT_RES),
    .BUS_RES(BUS_RES), .TEMP_RES(TEMP_RES), .CURRENT_RES(CURRENT_RES),
    .POWER_RES(POWER_RES), .DATA_READY(DATA_READY),
    .OVER_SHUNT(OVER_SHUNT), .OVER_BUS(OVER_BUS), .OVER_POWER(OVER_POWER),
    .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));
  pmcs_adc_model u_adc (.clk(CLK), .adc_chan(ADC_CHAN), .adc_soc(ADC_SOC),
    .shunt_v(shunt_v), .bus_v(bus_v), .temp_v(temp_v),
    .adc_sample(ADC_SAMPLE));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic lim_wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge CLK) LIM_WR = 1; LIM_ADDR = a; LIM_WDATA = d;
    @(negedge CLK) LIM_WR = 0;
  endtask
  // Clears ready, then counts cycles and starts until the next full set
  // The first start of a set shows in the clear cycle, so it is counted
  task automatic next_set;
    @(negedge CLK) READY_CLR = 1;
    socs = (ADC_SOC === 1'b1) ? 1 : 0;
    @(negedge CLK) READY_CLR = 0;
    cyc = 0;
    if (ADC_SOC === 1'b1) socs++;
    while (DATA_READY !== 1'b1 && cyc < 20000) begin
      @(negedge CLK); cyc++;
      if (ADC_SOC === 1'b1) socs++;
    end
    `CHK("ready", 1'b1, DATA_READY)
  endtask
  task automatic two_sets; next_set; next_set; endtask
  task automatic calc(input int cal);
    int s, cur;
    s = $signed(shunt_v); cur = (s * cal) >>> 12;
    e24 = 24'(((cur < 0 ? -cur : cur) * int'(bus_v)) >> 6);
    `CHK("current", 16'(cur), CURRENT_RES)
    `CHK("power", e24, POWER_RES)
  endtask
  task automatic t_power_up;
    two_sets;
    `CHK("sets", 3, socs)
    `CHK("shunt", shunt_v, SHUNT_RES)
    `CHK("bus", bus_v, BUS_RES)
    `CHK("temp", temp_v, TEMP_RES)
    `CHK("nocal", 16'h0000, CURRENT_RES)
    `CHK("flags", 3'b000, {OVER_SHUNT, OVER_BUS, OVER_POWER})
    `CHK("range", 1'b0, ADC_RANGE)
    $display("power up done");
  endtask
  task automatic t_cal;
    lim_wr(2'h3, 16'd4050); two_sets; calc(4050);
    shunt_v = 16'hB410; two_sets; calc(4050);
    `CHK("sign", 1'b1, CURRENT_RES[15])
    shunt_v = 16'h4BF0; two_sets; calc(4050);
    $display("calibration done");
  endtask
  task automatic t_limits;
    lim_wr(2'h0, 16'h4BEF); lim_wr(2'h1, 16'h3C00);
    lim_wr(2'h2, e24[23:8] - 16'h0001); two_sets;
    `CHK("over", 3'b101, {OVER_SHUNT, OVER_BUS, OVER_POWER})
    @(negedge CLK) `CHK("alert", 1'b1, ALERT_OE)
    lim_wr(2'h0, 16'h4BF0); lim_wr(2'h1, 16'h3BFF);
    lim_wr(2'h2, e24[23:8]); two_sets;
    `CHK("edge", 3'b010, {OVER_SHUNT, OVER_BUS, OVER_POWER})
    @(negedge CLK) RST = 1;
    repeat (8) @(negedge CLK);
    RST = 0; two_sets;
    `CHK("relim", 3'b000, {OVER_SHUNT, OVER_BUS, OVER_POWER})
    `CHK("recal", 16'h0000, CURRENT_RES)
    $display("limits done");
  endtask
  task automatic t_timing;
    for (int k = 0; k < 4; k++) begin
      AVG_SEL = 3'(k); two_sets;
      `CHK("avg", 3 << (2 * k), socs)
    end
    AVG_SEL = 3'h1; two_sets; c0 = cyc;
    SHUNT_CT_SEL = 3'h1; two_sets;
    `CHK("shunt_t", 4 * (84 - 50), cyc - c0)
    BUS_CT_SEL = 3'h2; two_sets;
    `CHK("bus_t", 4 * (84 - 50) + 4 * (150 - 50), cyc - c0)
    TEMP_CT_SEL = 3'h1; two_sets;
    `CHK("temp_t", 8 * (84 - 50) + 4 * (150 - 50), cyc - c0)
    AVG_SEL = 3'h0; SHUNT_CT_SEL = 3'h0; BUS_CT_SEL = 3'h0;
    TEMP_CT_SEL = 3'h0; next_set; c0 = cyc;
    for (int j = 1; j < 8; j++) begin
      SHUNT_CT_SEL = 3'(j); next_set;
      `CHK("ct_code", ct_us[j] - 50, cyc - c0)
    end
    SHUNT_CT_SEL = 3'h0;
    $display("timing done");
  endtask
  task automatic t_range;
    SHUNT_RANGE_SELECT = 1; ALERT_SEL = 1; shunt_v = 16'd4860;
    lim_wr(2'h3, 16'd16200); two_sets;
    `CHK("narrow", 1'b1, ADC_RANGE)
    calc(16200);
    `CHK("same_i", 16'd19221, CURRENT_RES)
    @(negedge CLK) `CHK("rdy_alert", 1'b1, ALERT_OE)
    $display("range done");
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    $display("watchdog expired");
    end_of_test;
  end
  initial begin
    repeat (8) @(negedge CLK);
    RST = 0;
    t_power_up;
    t_cal;
    t_limits;
    t_timing;
    t_range;
    end_of_test;
  end
endmodule // pmcs_top_test
`default_nettype wire
